// >>> rtl/sie_params.svh
`ifndef SIE_PARAMS_SVH
`define SIE_PARAMS_SVH
`define SIE_HINT_OPCODE  16'hBF40
`define SIE_OP5_MULTI    5'h18
`define SIE_OP5_WORD_IMM 5'h0C
`define SIE_OP5_BYTE_IMM 5'h0E
`define SIE_OP5_HALF_IMM 5'h10
`define SIE_OP5_WORD_SP  5'h12
`define SIE_OP7_WORD_REG 7'h28
`define SIE_OP7_BYTE_REG 7'h2A
`define SIE_SP_INDEX     4'hD
`define SIE_SIZE_BYTE    3'h1
`define SIE_SIZE_HALF    3'h2
`define SIE_SIZE_WORD    3'h4
`define SIE_WORD_STEP    32'h00000004
`endif

// >>> rtl/sie_pkg.sv
package sie_pkg;
   typedef enum logic [2:0] {
      SIE_OP_NONE,
      SIE_OP_HINT,
      SIE_OP_MULTI,
      SIE_OP_WORD,
      SIE_OP_BYTE,
      SIE_OP_HALF
   } sie_op_t;

   typedef struct packed {
      sie_op_t     op;
      logic [3:0]  base_reg;
      logic [3:0]  source_reg;
      logic [3:0]  offset_reg;
      logic        use_offset_reg;
      logic [31:0] imm32;
      logic [7:0]  list;
   } sie_dec_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic [31:0] data;
      logic [2:0]  size;
   } sie_mem_t;
endpackage

// >>> rtl/sie_decode.sv
`timescale 1ns/1ns
`include "sie_params.svh"
module sie_decode (
   input  wire logic [15:0]      instr_i,
   output sie_pkg::sie_dec_t     dec_o
);
   always_comb begin
      dec_o            = '0;
      dec_o.op         = sie_pkg::SIE_OP_NONE;
      // Three-bit selectors are zero-extended to R0..R7; only the SP-relative word form reaches R13 as base
      dec_o.source_reg = {1'b0, instr_i[2:0]};
      dec_o.base_reg   = {1'b0, instr_i[5:3]};
      dec_o.offset_reg = {1'b0, instr_i[8:6]};
      if (instr_i == `SIE_HINT_OPCODE) begin
         dec_o.op = sie_pkg::SIE_OP_HINT;
      end else if (instr_i[15:11] == `SIE_OP5_MULTI) begin
         dec_o.op       = sie_pkg::SIE_OP_MULTI;
         dec_o.base_reg = {1'b0, instr_i[10:8]};
         dec_o.list     = instr_i[7:0];
      end else if (instr_i[15:11] == `SIE_OP5_WORD_IMM) begin
         dec_o.op    = sie_pkg::SIE_OP_WORD;
         dec_o.imm32 = {25'h0000000, instr_i[10:6], 2'h0};
      end else if (instr_i[15:11] == `SIE_OP5_WORD_SP) begin
         dec_o.op         = sie_pkg::SIE_OP_WORD;
         dec_o.base_reg   = `SIE_SP_INDEX;
         dec_o.source_reg = {1'b0, instr_i[10:8]};
         dec_o.imm32      = {22'h000000, instr_i[7:0], 2'h0};
      end else if (instr_i[15:11] == `SIE_OP5_BYTE_IMM) begin
         dec_o.op    = sie_pkg::SIE_OP_BYTE;
         dec_o.imm32 = {27'h0000000, instr_i[10:6]};
      end else if (instr_i[15:11] == `SIE_OP5_HALF_IMM) begin
         dec_o.op    = sie_pkg::SIE_OP_HALF;
         dec_o.imm32 = {26'h0000000, instr_i[10:6], 1'b0};
      end else if (instr_i[15:9] == `SIE_OP7_WORD_REG) begin
         dec_o.op             = sie_pkg::SIE_OP_WORD;
         dec_o.use_offset_reg = 1'b1;
      end else if (instr_i[15:9] == `SIE_OP7_BYTE_REG) begin
         dec_o.op             = sie_pkg::SIE_OP_BYTE;
         dec_o.use_offset_reg = 1'b1;
      end
   end
endmodule

// >>> rtl/sie_exec.sv
`timescale 1ns/1ns
`include "sie_params.svh"
module sie_exec (
   input  wire logic               core_clk_i,
   input  wire logic               rst_i,
   input  wire logic               instr_valid_i,
   input  wire logic [15:0]        instr_i,
   output logic                    instr_ready_o,
   output logic [3:0]              rd_addr_a_o,
   output logic [3:0]              rd_addr_b_o,
   output logic [3:0]              rd_addr_c_o,
   input  wire logic [31:0]        rd_data_a_i,
   input  wire logic [31:0]        rd_data_b_i,
   input  wire logic [31:0]        rd_data_c_i,
   output logic                    wb_valid_o,
   output logic [3:0]              wb_addr_o,
   output logic [31:0]             wb_data_o,
   output sie_pkg::sie_mem_t       mem_o,
   input  wire logic               mem_ready_i,
   output logic                    event_o,
   output logic                    done_o
);
   typedef enum logic [2:0] {
      SIE_IDLE,
      SIE_READ,
      SIE_SINGLE,
      SIE_MULTI_RD,
      SIE_MULTI_WR,
      SIE_WBACK
   } sie_state_t;

   sie_state_t          state_q;
   sie_pkg::sie_dec_t   dec_w;
   sie_pkg::sie_dec_t   dec_q;
   logic [31:0]         addr_q;
   logic [15:0]         mask_q;
   logic [3:0]          cur_q;

   // Lowest set bit; mask is never empty by software contract
   function automatic logic [3:0] sie_lowest(input logic [15:0] m);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (m[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   sie_decode u_decode (
      .instr_i (instr_i),
      .dec_o   (dec_w)
   );

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_q       <= SIE_IDLE;
         dec_q         <= '0;
         addr_q        <= 32'h00000000;
         mask_q        <= 16'h0000;
         cur_q         <= 4'h0;
         instr_ready_o <= 1'b1;
         rd_addr_a_o   <= 4'h0;
         rd_addr_b_o   <= 4'h0;
         rd_addr_c_o   <= 4'h0;
         wb_valid_o    <= 1'b0;
         wb_addr_o     <= 4'h0;
         wb_data_o     <= 32'h00000000;
         mem_o         <= '0;
         event_o       <= 1'b0;
         done_o        <= 1'b0;
      end else begin
         event_o    <= 1'b0;
         done_o     <= 1'b0;
         wb_valid_o <= 1'b0;
         case (state_q)
            SIE_IDLE: begin
               if (instr_valid_i && instr_ready_o) begin
                  dec_q <= dec_w;
                  case (dec_w.op)
                     sie_pkg::SIE_OP_HINT: begin
                        // Only the event and done pulses; no register or memory change
                        event_o <= 1'b1;
                        done_o  <= 1'b1;
                     end
                     sie_pkg::SIE_OP_NONE: begin
                        done_o <= 1'b1;
                     end
                     default: begin
                        instr_ready_o <= 1'b0;
                        rd_addr_a_o   <= dec_w.base_reg;
                        rd_addr_b_o   <= dec_w.source_reg;
                        rd_addr_c_o   <= dec_w.offset_reg;
                        mask_q        <= {8'h00, dec_w.list};
                        state_q       <= SIE_READ;
                     end
                  endcase
               end
            end
            SIE_READ: begin
               if (dec_q.op == sie_pkg::SIE_OP_MULTI) begin
                  addr_q      <= rd_data_a_i;
                  cur_q       <= sie_lowest(mask_q);
                  rd_addr_b_o <= sie_lowest(mask_q);
                  state_q     <= SIE_MULTI_RD;
               end else begin
                  mem_o.valid <= 1'b1;
                  // Pre-indexed, added offset; base is never written back
                  mem_o.addr  <= rd_data_a_i + (dec_q.use_offset_reg ? rd_data_c_i : dec_q.imm32);
                  case (dec_q.op)
                     sie_pkg::SIE_OP_BYTE: begin
                        mem_o.data <= {24'h000000, rd_data_b_i[7:0]};
                        mem_o.size <= `SIE_SIZE_BYTE;
                     end
                     sie_pkg::SIE_OP_HALF: begin
                        mem_o.data <= {16'h0000, rd_data_b_i[15:0]};
                        mem_o.size <= `SIE_SIZE_HALF;
                     end
                     default: begin
                        mem_o.data <= rd_data_b_i;
                        mem_o.size <= `SIE_SIZE_WORD;
                     end
                  endcase
                  state_q <= SIE_SINGLE;
               end
            end
            SIE_SINGLE: begin
               if (mem_ready_i) begin
                  mem_o.valid   <= 1'b0;
                  instr_ready_o <= 1'b1;
                  done_o        <= 1'b1;
                  state_q       <= SIE_IDLE;
               end
            end
            SIE_MULTI_RD: begin
               // Register read settles one cycle before the word leaves
               // Base stored as read; value is only meaningful if it is lowest
               mem_o.valid <= 1'b1;
               mem_o.addr  <= addr_q;
               mem_o.data  <= rd_data_b_i;
               mem_o.size  <= `SIE_SIZE_WORD;
               mask_q      <= mask_q & ~(16'h0001 << cur_q);
               state_q     <= SIE_MULTI_WR;
            end
            SIE_MULTI_WR: begin
               if (mem_ready_i) begin
                  mem_o.valid <= 1'b0;
                  addr_q      <= addr_q + `SIE_WORD_STEP;
                  if (mask_q == 16'h0000) begin
                     state_q <= SIE_WBACK;
                  end else begin
                     cur_q       <= sie_lowest(mask_q);
                     rd_addr_b_o <= sie_lowest(mask_q);
                     state_q     <= SIE_MULTI_RD;
                  end
               end
            end
            SIE_WBACK: begin
               wb_valid_o    <= 1'b1;
               wb_addr_o     <= dec_q.base_reg;
               wb_data_o     <= addr_q;
               instr_ready_o <= 1'b1;
               done_o        <= 1'b1;
               state_q       <= SIE_IDLE;
            end
            default: begin
               state_q       <= SIE_IDLE;
               instr_ready_o <= 1'b1;
            end
         endcase
      end
   end
endmodule

// >>> sim/sie_exec_assertions.sv
`timescale 1ns/1ns
`include "sie_params.svh"
module sie_exec_assertions (
   input wire logic              core_clk_i,
   input wire logic              rst_i,
   input wire logic              instr_valid_i,
   input wire logic [15:0]       instr_i,
   input wire logic              instr_ready_o,
   input wire logic              wb_valid_o,
   input wire sie_pkg::sie_mem_t mem_o,
   input wire logic              mem_ready_i,
   input wire logic              event_o,
   input wire logic              done_o
);
   logic       multi_q;
   logic [2:0] sz_q;
   wire        acc = instr_valid_i && instr_ready_o;
   wire        hint = acc && instr_i == `SIE_HINT_OPCODE;
   function automatic logic [2:0] sz(input logic [15:0] i);
      if (i[15:11] inside {`SIE_OP5_WORD_IMM, `SIE_OP5_WORD_SP, `SIE_OP5_MULTI} || i[15:9] == `SIE_OP7_WORD_REG)
         return `SIE_SIZE_WORD;
      if (i[15:11] == `SIE_OP5_BYTE_IMM || i[15:9] == `SIE_OP7_BYTE_REG)
         return `SIE_SIZE_BYTE;
      if (i[15:11] == `SIE_OP5_HALF_IMM)
         return `SIE_SIZE_HALF;
      return 3'h0;
   endfunction
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         multi_q <= 1'b0;
         sz_q    <= 3'h0;
      end else if (acc) begin
         multi_q <= instr_i[15:11] == `SIE_OP5_MULTI;
         sz_q    <= sz(instr_i);
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   hint_event_a: assert property (hint |=> event_o && done_o) else $error("event pulse missing");
   event_cause_a: assert property (event_o |-> $past(hint)) else $error("stray event");
   hint_quiet_a: assert property (hint |=> !mem_o.valid && !wb_valid_o) else $error("hint touched state");
   mem_start_a: assert property (acc && sz(instr_i) != 3'h0 |-> ##[1:4] mem_o.valid) else $error("no write");
   mem_hold_a: assert property (mem_o.valid && !mem_ready_i |=> mem_o.valid && $stable(mem_o))
      else $error("write changed before accept");
   size_match_a: assert property (mem_o.valid |-> mem_o.size == sz_q) else $error("bad size");
   wb_multi_only_a: assert property (wb_valid_o |-> multi_q) else $error("base updated");
   wb_done_a: assert property (wb_valid_o |-> ##[0:1] done_o) else $error("writeback not final");
endmodule

// >>> sim/sie_mem_model.sv
`timescale 1ns/1ns
module sie_mem_model (
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   input  wire logic              slow_i,
   input  wire logic [3:0]        rd_addr_a_i,
   input  wire logic [3:0]        rd_addr_b_i,
   input  wire logic [3:0]        rd_addr_c_i,
   output logic      [31:0]       rd_data_a_o,
   output logic      [31:0]       rd_data_b_o,
   output logic      [31:0]       rd_data_c_o,
   input  wire sie_pkg::sie_mem_t mem_i,
   output logic                   mem_ready_o
);
   int   cnt;
   logic v;
   logic r;
   // Contents follow the index so the bench can predict them without a shared table
   assign rd_data_a_o = 32'h01234567 ^ {8{rd_addr_a_i}};
   assign rd_data_b_o = 32'h01234567 ^ {8{rd_addr_b_i}};
   assign rd_data_c_o = 32'h01234567 ^ {8{rd_addr_c_i}};
   initial mem_ready_o = 1'b0;
   always @(posedge core_clk_i) begin
      v = mem_i.valid;
      r = mem_ready_o;
      #5;
      if (rst_i || !v || r) begin
         mem_ready_o = 1'b0;
         cnt = 0;
      end else if (cnt >= (slow_i ? 3 : 0))
         mem_ready_o = 1'b1;
      else
         cnt++;
   end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ns
`include "sie_params.svh"
module tb;
   logic              clk = 1'b0, rst = 1'b1, iv = 1'b0, slow = 1'b0;
   logic [15:0]       ins = 16'h0000;
   logic              ready, wbv, mrdy, ev, dn;
   logic [3:0]        ra, rb, rc, wba;
   logic [31:0]       da, db, dc, wbd;
   sie_pkg::sie_mem_t mem;
   sie_pkg::sie_mem_t wq[$];
   logic [35:0]       wbq[$];
   int                evs, dns, fails, total_checks, cyc;
   sie_exec dut (.core_clk_i(clk), .rst_i(rst), .instr_valid_i(iv), .instr_i(ins), .instr_ready_o(ready),
      .rd_addr_a_o(ra), .rd_addr_b_o(rb), .rd_addr_c_o(rc), .rd_data_a_i(da), .rd_data_b_i(db),
      .rd_data_c_i(dc), .wb_valid_o(wbv), .wb_addr_o(wba), .wb_data_o(wbd), .mem_o(mem),
      .mem_ready_i(mrdy), .event_o(ev), .done_o(dn));
   sie_mem_model u_mem (.core_clk_i(clk), .rst_i(rst), .slow_i(slow), .rd_addr_a_i(ra), .rd_addr_b_i(rb),
      .rd_addr_c_i(rc), .rd_data_a_o(da), .rd_data_b_o(db), .rd_data_c_o(dc), .mem_i(mem), .mem_ready_o(mrdy));
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (mem.valid === 1'b1 && mrdy === 1'b1)
         wq.push_back(mem);
      if (wbv === 1'b1)
         wbq.push_back({wba, wbd});
      if (ev === 1'b1)
         evs++;
      if (dn === 1'b1)
         dns++;
      if (cyc == 3000) begin
         fails++;
         wrap_up();
      end
   end
   function automatic logic [31:0] rf(input logic [3:0] i);
      return 32'h01234567 ^ {8{i}};
   endfunction
   task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Offered just after an edge; held until the edge that samples ready high
   task automatic run(input logic [15:0] i);
      int n;
      wq.delete();
      wbq.delete();
      evs = 0;
      dns = 0;
      n = 0;
      iv = 1'b1;
      ins = i;
      do begin
         @(posedge clk);
         n++;
      end while (ready !== 1'b1 && n < 20);
      #5 iv = 1'b0;
      n = 0;
      while (dns == 0 && n < 60) begin
         @(posedge clk);
         #5 n++;
      end
      chk("done", dns, 1);
   endtask
   task automatic sgl(input logic [15:0] i, input logic [31:0] a, input logic [31:0] d, input logic [2:0] s,
                      input logic [31:0] m);
      run(i);
      chk("writes", wq.size(), 1);
      chk("address", wq[0].addr, a);
      chk("data", wq[0].data & m, d & m);
      chk("size", wq[0].size, s);
      chk("writebacks", wbq.size(), 0);
   endtask
   task automatic multi(input logic [2:0] rn, input logic [7:0] lst);
      int k;
      k = 0;
      run({`SIE_OP5_MULTI, rn, lst});
      for (int r = 0; r < 8; r++) begin
         if (lst[r]) begin
            chk("multi addr", wq[k].addr, rf(rn) + 32'(4 * k));
            chk("multi data", wq[k].data, rf(4'(r)));
            k++;
         end
      end
      chk("multi words", wq.size(), k);
      chk("multi base", wbq[0], {1'b0, rn, rf(rn) + 32'(4 * k)});
   endtask
   task automatic t_hint;
      run(`SIE_HINT_OPCODE);
      chk("event", evs, 1);
      chk("no state", wq.size() + wbq.size(), 0);
      $display("hint test done");
   endtask
   task automatic t_word;
      sgl(16'h67D5, rf(2) + 32'd124, rf(5), 3'h4, 32'hFFFFFFFF);
      sgl(16'h93FF, rf(`SIE_SP_INDEX) + 32'd1020, rf(3), 3'h4, 32'hFFFFFFFF);
      sgl(16'h518F, rf(1) + rf(6), rf(7), 3'h4, 32'hFFFFFFFF);
      $display("word test done");
   endtask
   task automatic t_byte;
      sgl(16'h77DC, rf(3) + 32'd31, rf(4), 3'h1, 32'h000000FF);
      sgl(16'h54AE, rf(5) + rf(2), rf(6), 3'h1, 32'h000000FF);
      $display("byte test done");
   endtask
   task automatic t_half;
      sgl(16'h87F9, rf(7) + 32'd62, rf(1), 3'h2, 32'h0000FFFF);
      sgl(16'h8002, rf(0), rf(2), 3'h2, 32'h0000FFFF);
      sgl(16'h6020, rf(4), rf(0), 3'h4, 32'hFFFFFFFF);
      $display("half test done");
   endtask
   task automatic t_multi;
      // Slow memory proves each word is held until taken
      slow = 1'b1;
      multi(3'h3, 8'hA5);
      multi(3'h0, 8'h80);
      slow = 1'b0;
      $display("multi test done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #5 rst = 1'b0;
      t_hint();
      t_word();
      t_byte();
      t_half();
      t_multi();
      wrap_up();
   end
endmodule
bind sie_exec sie_exec_assertions u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
   .instr_i(instr_i), .instr_ready_o(instr_ready_o), .wb_valid_o(wb_valid_o), .mem_o(mem_o),
   .mem_ready_i(mem_ready_i), .event_o(event_o), .done_o(done_o));
